// File: src/wse_top.sv
// How it works
// - opcode 101011 decodes word store; address is base plus sign-extended 16-bit offset.
// - word store writes low 32 bits of the source register.
// - before release 6, nonzero low two address bits raise address error, no write.
// - release 6 accepts misaligned word stores in hardware.
// - word store faults: refill, invalid, modified, address error, watch only.
// - fp word store writes low 32 fp bits to base plus 16-bit offset.
// - fp stores also raise coprocessor-unusable; cop2 stores also raise coprocessor-unusable or reserved-instruction.
// - cop2 word store writes low 32 bits of the cop2 register.
// - cop2 offset is 11 bits in release 6, else 16, sign-extended.
// - user-space kernel store: 011111/011111, bit 6 zero, 9-bit offset.
// - it translates through user mapping for mapped-user segments.
// - it exists only when extended addressing is present.
// - it is legal only in kernel mode and permitted segment modes.
// - indexed doubleword store writes 64 bits to aligned base plus index.
// - indexed doubleword store is undefined in the 32-bit register model.
// - indexed doubleword store raises no address error.
`timescale 1ns/1ps
module wse_top
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// instruction and operands
	input  wire logic [31:0]       instr,
	input  wire logic              instr_valid,
	input  wire logic [31:0]       base_value,
	input  wire logic [31:0]       index_value,
	input  wire logic [31:0]       gpr_data,
	input  wire logic [63:0]       fpr_data,
	input  wire logic [31:0]       cop2_data,
	// configuration
	input  wire logic              release6_mode,
	input  wire logic              extended_addressing_present,
	input  wire logic              kernel_mode,
	input  wire logic              cop1_usable,
	input  wire logic              cop2_usable,
	input  wire logic              cop2_present,
	input  wire logic              fp_register_model_select,
	input  wire logic              fpu_is_64bit,
	input  wire wse_pkg::wse_seg_e target_segment_mode,
	// translation answer, same cycle as the request
	input  wire logic [31:0]       tlb_paddr,
	input  wire logic [2:0]        tlb_cacheability_attribute,
	input  wire logic              tlb_refill,
	input  wire logic              tlb_invalid,
	input  wire logic              tlb_page_clean,
	input  wire logic              watch_match,
	// translation request
	output logic [31:0]            xlat_vaddr,
	output logic                   xlat_user_map,
	// memory write
	output logic                   mem_write,
	output logic [31:0]            mem_paddr,
	output logic [2:0]             mem_cacheability_attribute,
	output logic [63:0]            mem_data,
	output logic [7:0]             mem_byte_en,
	output logic                   mem_dword,
	// exception report
	output logic                   exc_valid,
	output wse_pkg::wse_exc_e      exc_code
);
	wse_dec_if         dec_bus ();
	wse_pkg::wse_exc_e exc_now;
	logic [63:0]       data_now;
	logic [31:0]       paddr_now;

	wse_decode u_decode
	(
		.instr                       (instr),
		.instr_valid                 (instr_valid),
		.base_value                  (base_value),
		.index_value                 (index_value),
		.release6_mode               (release6_mode),
		.extended_addressing_present (extended_addressing_present),
		.kernel_mode                 (kernel_mode),
		.cop1_usable                 (cop1_usable),
		.cop2_usable                 (cop2_usable),
		.fp_register_model_select    (fp_register_model_select),
		.fpu_is_64bit                (fpu_is_64bit),
		.cop2_present                (cop2_present),
		.target_segment_mode         (target_segment_mode),
		.d                           (dec_bus)
	);

	wse_exec u_exec
	(
		.d              (dec_bus),
		.tlb_refill     (tlb_refill),
		.tlb_invalid    (tlb_invalid),
		.tlb_page_clean (tlb_page_clean),
		.watch_match    (watch_match),
		.exc_code       (exc_now)
	);

	// ----------------------------------------------------------------
	// data selection
	// ----------------------------------------------------------------
	always_comb
	begin
		data_now  = wse_pkg::ZERO_DWORD;
		paddr_now = tlb_paddr;
		case (dec_bus.op)
			wse_pkg::WSE_OP_GPR:  data_now = {wse_pkg::ZERO_WORD, gpr_data};
			wse_pkg::WSE_OP_USK:  data_now = {wse_pkg::ZERO_WORD, gpr_data};
			wse_pkg::WSE_OP_FP:   data_now = {wse_pkg::ZERO_WORD, fpr_data[31:0]};
			wse_pkg::WSE_OP_COP2: data_now = {wse_pkg::ZERO_WORD, cop2_data};
			wse_pkg::WSE_OP_DWIU:
			begin
				data_now  = fpr_data;
				paddr_now = {tlb_paddr[31:3], 3'b000};
			end
			default: data_now = wse_pkg::ZERO_DWORD;
		endcase
	end

	// translation request is combinational to meet the same-cycle answer
	assign xlat_vaddr    = dec_bus.eff_addr;
	assign xlat_user_map = dec_bus.user_map;

	// ----------------------------------------------------------------
	// memory write stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_write                  <= 1'b0;
			mem_paddr                  <= wse_pkg::ZERO_WORD;
			mem_cacheability_attribute <= 3'h0;
			mem_data                   <= wse_pkg::ZERO_DWORD;
			mem_byte_en                <= 8'h00;
			mem_dword                  <= 1'b0;
		end
		else
		begin
			// faulted stores leave the memory untouched, no partial lanes
			mem_write <= dec_bus.valid && exc_now == wse_pkg::WSE_EXC_NONE;
			if (dec_bus.valid && exc_now == wse_pkg::WSE_EXC_NONE)
			begin
				mem_paddr                  <= paddr_now;
				mem_cacheability_attribute <= tlb_cacheability_attribute;
				mem_data                   <= data_now;
				mem_dword                  <= (dec_bus.op == wse_pkg::WSE_OP_DWIU);
				mem_byte_en                <= (dec_bus.op == wse_pkg::WSE_OP_DWIU)
					? 8'hFF : 8'h0F;
			end
			else
				mem_byte_en <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// exception report
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			exc_valid <= 1'b0;
			exc_code  <= wse_pkg::WSE_EXC_NONE;
		end
		else
		begin
			exc_valid <= dec_bus.valid && exc_now != wse_pkg::WSE_EXC_NONE;
			exc_code  <= exc_now;
		end
	end
endmodule

// File: src/wse_pkg.sv
package wse_pkg;

	// ----------------------------------------------------------------
	// instruction fields
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_STORE_WORD_GPR   = 6'h2B;
	localparam logic [5:0] OP_STORE_WORD_FP    = 6'h39;
	localparam logic [5:0] OP_STORE_WORD_COP2  = 6'h3A;
	localparam logic [5:0] OP_EXTENDED_MAJOR   = 6'h1F;
	localparam logic [5:0] FN_STORE_WORD_USK   = 6'h1F;
	localparam logic [5:0] OP_FP_INDEXED       = 6'h13;
	localparam logic [5:0] FN_STORE_DWORD_IU   = 6'h0D;
	localparam logic [5:0] OP_R6_COP2_GROUP    = 6'h12;
	localparam logic [4:0] RS_R6_STORE_WORD_C2 = 5'h0B;

	localparam int OPC_HI    = 31;
	localparam int OPC_LO    = 26;
	localparam int FN_HI     = 5;
	localparam int FN_LO     = 0;
	localparam int BIT6_POS  = 6;
	localparam int OFF16_W   = 16;
	localparam int OFF11_W   = 11;
	localparam int OFF9_HI   = 15;
	localparam int OFF9_LO   = 7;
	localparam int OFF9_W    = 9;

	// ----------------------------------------------------------------
	// operation kinds and segment modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		WSE_OP_NONE,
		WSE_OP_GPR,
		WSE_OP_FP,
		WSE_OP_COP2,
		WSE_OP_USK,
		WSE_OP_DWIU
	} wse_op_e;

	typedef enum logic [1:0]
	{
		// mapped for user only, unmapped for all, mapped for all
		WSE_SEG_MAP_USER,
		WSE_SEG_UNMAP_ALL,
		WSE_SEG_MAP_ALL,
		WSE_SEG_OTHER
	} wse_seg_e;

	// exception cause codes reported to the pipeline
	typedef enum logic [3:0]
	{
		WSE_EXC_NONE,
		WSE_EXC_TLB_REFILL,
		WSE_EXC_TLB_INVALID,
		WSE_EXC_TLB_MODIFIED,
		WSE_EXC_ADDR_ERROR,
		WSE_EXC_WATCH,
		WSE_EXC_COP_UNUSABLE,
		WSE_EXC_RESERVED_INSTR
	} wse_exc_e;

	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [63:0] ZERO_DWORD = 64'h0000_0000_0000_0000;

endpackage

// File: src/wse_dec_if.sv
`timescale 1ns/1ps
interface wse_dec_if;
	logic                 valid;
	wse_pkg::wse_op_e     op;
	logic [31:0]          eff_addr;
	logic                 misaligned;
	logic                 reserved;
	logic                 cop_unusable;
	logic                 user_map;

	modport dec (output valid, op, eff_addr, misaligned, reserved, cop_unusable, user_map);
	modport exe (input valid, op, eff_addr, misaligned, reserved, cop_unusable, user_map);
endinterface

// File: src/wse_decode.sv
`timescale 1ns/1ps
module wse_decode
(
	// instruction and operands
	input  wire logic [31:0]      instr,
	input  wire logic             instr_valid,
	input  wire logic [31:0]      base_value,
	input  wire logic [31:0]      index_value,
	// configuration
	input  wire logic             release6_mode,
	input  wire logic             extended_addressing_present,
	input  wire logic             kernel_mode,
	input  wire logic             cop1_usable,
	input  wire logic             cop2_usable,
	input  wire logic             fp_register_model_select,
	input  wire logic             fpu_is_64bit,
	input  wire logic             cop2_present,
	input  wire wse_pkg::wse_seg_e target_segment_mode,
	// decoded result
	wse_dec_if.dec                d
);
	logic [5:0]  opc;
	logic [5:0]  fn;
	logic [31:0] off16_sx;
	logic [31:0] off11_sx;
	logic [31:0] off9_sx;
	logic        seg_ok;

	assign opc      = instr[wse_pkg::OPC_HI:wse_pkg::OPC_LO];
	assign fn       = instr[wse_pkg::FN_HI:wse_pkg::FN_LO];
	assign off16_sx = {{(32-wse_pkg::OFF16_W){instr[15]}}, instr[15:0]};
	assign off11_sx = {{(32-wse_pkg::OFF11_W){instr[10]}}, instr[10:0]};
	assign off9_sx  = {{(32-wse_pkg::OFF9_W){instr[wse_pkg::OFF9_HI]}},
		instr[wse_pkg::OFF9_HI:wse_pkg::OFF9_LO]};
	assign seg_ok   = (target_segment_mode != wse_pkg::WSE_SEG_OTHER);

	always_comb
	begin
		d.valid        = 1'b0;
		d.op           = wse_pkg::WSE_OP_NONE;
		d.eff_addr     = wse_pkg::ZERO_WORD;
		d.reserved     = 1'b0;
		d.cop_unusable = 1'b0;
		d.user_map     = 1'b0;
		if (instr_valid && opc == wse_pkg::OP_STORE_WORD_GPR)
		begin
			d.valid    = 1'b1;
			d.op       = wse_pkg::WSE_OP_GPR;
			d.eff_addr = base_value + off16_sx;
		end
		else if (instr_valid && opc == wse_pkg::OP_STORE_WORD_FP && !release6_mode)
		begin
			d.valid        = 1'b1;
			d.op           = wse_pkg::WSE_OP_FP;
			d.eff_addr     = base_value + off16_sx;
			d.cop_unusable = !cop1_usable;
		end
		else if (instr_valid && !release6_mode && opc == wse_pkg::OP_STORE_WORD_COP2)
		begin
			d.valid        = 1'b1;
			d.op           = wse_pkg::WSE_OP_COP2;
			d.eff_addr     = base_value + off16_sx;
			d.reserved     = !cop2_present;
			d.cop_unusable = cop2_present && !cop2_usable;
		end
		else if (instr_valid && release6_mode && opc == wse_pkg::OP_R6_COP2_GROUP
			&& instr[25:21] == wse_pkg::RS_R6_STORE_WORD_C2)
		begin
			d.valid        = 1'b1;
			d.op           = wse_pkg::WSE_OP_COP2;
			d.eff_addr     = base_value + off11_sx;
			d.reserved     = !cop2_present;
			d.cop_unusable = cop2_present && !cop2_usable;
		end
		else if (instr_valid && opc == wse_pkg::OP_EXTENDED_MAJOR
			&& fn == wse_pkg::FN_STORE_WORD_USK && !instr[wse_pkg::BIT6_POS])
		begin
			d.valid    = 1'b1;
			d.op       = wse_pkg::WSE_OP_USK;
			d.eff_addr = base_value + off9_sx;
			// absent feature, user mode or a foreign segment mode all refuse
			d.reserved = !extended_addressing_present || !kernel_mode || !seg_ok;
			d.user_map = (target_segment_mode == wse_pkg::WSE_SEG_MAP_USER);
		end
		else if (instr_valid && !release6_mode && opc == wse_pkg::OP_FP_INDEXED
			&& fn == wse_pkg::FN_STORE_DWORD_IU)
		begin
			d.valid        = 1'b1;
			d.op           = wse_pkg::WSE_OP_DWIU;
			d.eff_addr     = base_value + index_value;
			// 32-bit model is unpredictable: refused here as a safe choice
			d.reserved     = !fpu_is_64bit || !fp_register_model_select;
			d.cop_unusable = !cop1_usable;
		end
	end

	// alignment: doubleword form ignores low bits, release 6 fixes it up
	assign d.misaligned = (d.op != wse_pkg::WSE_OP_DWIU) && !release6_mode
		&& (d.eff_addr[1:0] != 2'b00);
endmodule

// File: src/wse_exec.sv
`timescale 1ns/1ps
module wse_exec
(
	// decoded request
	wse_dec_if.exe                d,
	// translation result
	input  wire logic             tlb_refill,
	input  wire logic             tlb_invalid,
	input  wire logic             tlb_page_clean,
	input  wire logic             watch_match,
	// classification
	output wse_pkg::wse_exc_e     exc_code
);
	always_comb
	begin
		exc_code = wse_pkg::WSE_EXC_NONE;
		if (!d.valid)
			exc_code = wse_pkg::WSE_EXC_NONE;
		else if (d.reserved)
			exc_code = wse_pkg::WSE_EXC_RESERVED_INSTR;
		else if (d.cop_unusable)
			exc_code = wse_pkg::WSE_EXC_COP_UNUSABLE;
		else if (d.misaligned)
			exc_code = wse_pkg::WSE_EXC_ADDR_ERROR;
		else if (tlb_refill)
			exc_code = wse_pkg::WSE_EXC_TLB_REFILL;
		else if (tlb_invalid)
			exc_code = wse_pkg::WSE_EXC_TLB_INVALID;
		else if (tlb_page_clean)
			exc_code = wse_pkg::WSE_EXC_TLB_MODIFIED;
		else if (watch_match)
			exc_code = wse_pkg::WSE_EXC_WATCH;
	end
endmodule

// File: verification/wse_xlat_model.sv
`timescale 1ns/1ps
module wse_xlat_model
(
	// request
	input  wire logic [31:0] xlat_vaddr,
	input  wire logic        xlat_user_map,
	input  wire logic [3:0]  flt,
	// answer
	output logic [31:0]      tlb_paddr,
	output logic [2:0]       tlb_cacheability_attribute,
	output logic             tlb_refill,
	output logic             tlb_invalid,
	output logic             tlb_page_clean,
	output logic             watch_match
);
	// ----------------------------------------------------------------
	// translation
	// ----------------------------------------------------------------
	// user map lands on another frame, so a wrong map select shows in the address
	assign tlb_paddr = {~xlat_vaddr[31:29], xlat_vaddr[28:0]}
		^ {1'b0, xlat_user_map, 30'h0};
	// attribute taken above the dword offset, so dword masking cannot disturb it
	assign tlb_cacheability_attribute = xlat_vaddr[5:3];
	assign {watch_match, tlb_page_clean, tlb_invalid, tlb_refill} = flt;
endmodule

// File: verification/wse_top_sva.sv
`timescale 1ns/1ps
module wse_top_sva
(
	// clock, reset, request
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [31:0]       instr,
	input wire logic              instr_valid,
	input wire logic [31:0]       base_value,
	input wire logic [31:0]       gpr_data,
	// configuration
	input wire logic              release6_mode,
	input wire logic              extended_addressing_present,
	input wire logic              kernel_mode,
	input wire logic              cop1_usable,
	input wire logic              fp_register_model_select,
	input wire logic              fpu_is_64bit,
	input wire wse_pkg::wse_seg_e target_segment_mode,
	// translation
	input wire logic [31:0]       tlb_paddr,
	input wire logic              tlb_refill,
	input wire logic              tlb_invalid,
	input wire logic              tlb_page_clean,
	input wire logic              watch_match,
	input wire logic [31:0]       xlat_vaddr,
	input wire logic              xlat_user_map,
	// results
	input wire logic              mem_write,
	input wire logic [31:0]       mem_paddr,
	input wire logic [63:0]       mem_data,
	input wire logic [7:0]        mem_byte_en,
	input wire logic              exc_valid,
	input wire wse_pkg::wse_exc_e exc_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic wst = instr_valid && instr[31:26] == 6'h2B;
	wire logic dw  = instr_valid && instr[31:26] == 6'h13 && instr[5:0] == 6'h0D;
	wire logic usk = instr_valid && instr[31:26] == 6'h1F && instr[5:0] == 6'h1F && !instr[6];
	wire logic ok  = !(tlb_refill || tlb_invalid || tlb_page_clean || watch_match);
	wire logic fok = cop1_usable && fp_register_model_select && fpu_is_64bit && !release6_mode;
	AST_EXC_NO_WRITE: assert property (!(mem_write && exc_valid))
		else $error("write issued together with a fault");
	AST_SW_EA: assert property (wst |-> xlat_vaddr == base_value + 32'($signed(instr[15:0])))
		else $error("word store address wrong");
	AST_SW_ALIGN: assert property (wst && !release6_mode && xlat_vaddr[1:0] != 2'h0
		|=> exc_valid && exc_code == wse_pkg::WSE_EXC_ADDR_ERROR) else $error("no address fault");
	AST_SW_WORD: assert property (wst && ok && (release6_mode || xlat_vaddr[1:0] == 2'h0)
		|=> mem_write && mem_data[31:0] == $past(gpr_data) && mem_byte_en == 8'h0F)
		else $error("word store not written");
	AST_SW_CAUSES: assert property (wst |=> !(exc_code inside {wse_pkg::WSE_EXC_COP_UNUSABLE,
		wse_pkg::WSE_EXC_RESERVED_INSTR})) else $error("word store gave foreign fault");
	AST_DW_WRITE: assert property (dw && fok && ok |=> mem_write && mem_byte_en == 8'hFF
		&& mem_paddr == ($past(tlb_paddr) & 32'hFFFF_FFF8)) else $error("dword store wrong");
	AST_DW_NO_AE: assert property (dw |=> exc_code != wse_pkg::WSE_EXC_ADDR_ERROR)
		else $error("dword store gave address fault");
	AST_DW_MODEL: assert property (dw && !release6_mode && !fp_register_model_select
		|=> exc_code == wse_pkg::WSE_EXC_RESERVED_INSTR) else $error("dword store in 32-bit model");
	AST_USK_LEGAL: assert property (usk && !(extended_addressing_present && kernel_mode)
		|=> exc_valid ##0 exc_code == wse_pkg::WSE_EXC_RESERVED_INSTR) else $error("usk not refused");
	AST_USK_MAP: assert property (usk && extended_addressing_present && kernel_mode
		&& target_segment_mode == wse_pkg::WSE_SEG_MAP_USER |-> xlat_user_map)
		else $error("no user map");
	AST_COV_DW: cover property (mem_write && mem_byte_en == 8'hFF);
	AST_COV_AE: cover property (exc_valid && exc_code == wse_pkg::WSE_EXC_ADDR_ERROR);
	AST_COV_USK: cover property (usk ##1 mem_write);
	AST_COV_RI: cover property (exc_valid && exc_code == wse_pkg::WSE_EXC_RESERVED_INSTR);
endmodule
bind wse_top wse_top_sva u_sva (.*);

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic              clk = 0, rst_n = 0, instr_valid = 0, cop2_present = 1;
	logic [31:0]       instr = '0, base_value = '0, index_value = '0, gpr_data = '0, cop2_data = '0;
	logic [63:0]       fpr_data = '0;
	logic              release6_mode = 0, extended_addressing_present = 0, kernel_mode = 0;
	logic              cop1_usable = 0, cop2_usable = 0, fp_register_model_select = 0;
	logic              fpu_is_64bit = 0;
	wse_pkg::wse_seg_e target_segment_mode = wse_pkg::WSE_SEG_MAP_USER;
	logic [3:0]        flt = '0;
	logic [31:0]       tlb_paddr, xlat_vaddr, mem_paddr, r, ea, pa, d, m;
	logic [2:0]        tlb_cacheability_attribute, mem_cacheability_attribute;
	logic              tlb_refill, tlb_invalid, tlb_page_clean, watch_match, xlat_user_map;
	logic              mem_write, mem_dword, exc_valid, v, ri, cu, ae, umap;
	logic [63:0]       mem_data;
	logic [7:0]        mem_byte_en;
	wse_pkg::wse_exc_e exc_code;
	int                err_count = 0, comparisons = 0, cycles = 0, k, e;
	wse_top uut (.*);
	wse_xlat_model pm (.*);
	always #5 clk = ~clk;
	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// the loop should need about 3000 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			err_count++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end
	// ----------------------------------------------------------------
	// random back-to-back requests against a reference model
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32158));
		repeat (3) @(negedge clk);
		rst_n = 1;
		chk(mem_write, 0, "write in reset");
		for (int i = 0; i < 3000; i++)
		begin
			k = $urandom % 6;
			r = $urandom;
			{release6_mode, extended_addressing_present, kernel_mode, cop1_usable, cop2_usable,
				fp_register_model_select, fpu_is_64bit, cop2_present} = 8'($urandom);
			target_segment_mode = wse_pkg::wse_seg_e'(2'($urandom));
			flt = 4'($urandom & $urandom);
			{base_value, index_value, gpr_data, cop2_data} = {$urandom, $urandom, $urandom, $urandom};
			fpr_data = {$urandom, $urandom};
			instr_valid = ($urandom % 8) != 0;
			// fp word and indexed dword forms exist only before release 6
			if (k == 1 || k == 4)
				release6_mode = 0;
			case (k)
				0: instr = {6'h2B, r[25:0]};
				1: instr = {6'h39, r[25:0]};
				2: instr = release6_mode ? {6'h12, 5'h0B, r[20:0]} : {6'h3A, r[25:0]};
				3: instr = {6'h1F, r[25:7], 1'b0, 6'h1F};
				4: instr = {6'h13, r[25:11], 5'h00, 6'h0D};
				default: instr = {6'h00, r[25:0]};
			endcase
			v = instr_valid && k < 5;
			ea = k == 4 ? base_value + index_value : base_value + (k == 3 ? 32'($signed(r[15:7]))
				: k == 2 && release6_mode ? 32'($signed(r[10:0])) : 32'($signed(r[15:0])));
			m = k == 4 ? 32'hFFFF_FFF8 : 32'hFFFF_FFFF;
			umap = k == 3 && target_segment_mode == wse_pkg::WSE_SEG_MAP_USER;
			pa = {~ea[31:29], ea[28:0]} ^ {1'b0, umap, 30'h0};
			d = k == 0 || k == 3 ? gpr_data : k == 1 ? fpr_data[31:0] : cop2_data;
			ri = k == 4 && !(fp_register_model_select && fpu_is_64bit) || k == 2 && !cop2_present
				|| k == 3 && !(extended_addressing_present && kernel_mode
				&& target_segment_mode != 2'h3);
			cu = k == 1 || k == 4 ? !cop1_usable : k == 2 && !cop2_usable;
			ae = k != 4 && !release6_mode && ea[1:0] != 2'h0;
			e = ri ? 7 : cu ? 6 : ae ? 4 : flt[0] ? 1 : flt[1] ? 2 : flt[2] ? 3 : flt[3] ? 5 : 0;
			#1;
			if (v)
				chk(xlat_vaddr & m, ea & m, "address");
			chk(xlat_user_map, v && umap, "user map");
			@(negedge clk);
			chk(mem_write, v && e == 0, "write");
			chk(exc_valid, v && e != 0, "fault flag");
			chk(exc_code, v ? e : 0, "fault code");
			chk(mem_byte_en, !(v && e == 0) ? 8'h00 : k == 4 ? 8'hFF : 8'h0F, "lanes");
			if (v && e == 0)
			begin
				chk(mem_paddr, pa & m, "paddr");
				chk(mem_cacheability_attribute, ea[5:3], "attribute");
				chk(k == 4 ? mem_data : mem_data[31:0], k == 4 ? fpr_data : d, "data");
				chk(mem_dword, k == 4, "size");
			end
		end
		finish_test();
	end
endmodule
